/* hdl/twi_flags_pkg.sv */
// Shared constants for the two-wire status flag block
package twi_flags_pkg;

  // ****************************************************************
  // Register bus geometry and offsets
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned EVT_W  = 7;

  localparam logic [7:0] OFS_STATUS    = 8'h00;
  localparam logic [7:0] OFS_EVENT     = 8'h04;
  localparam logic [7:0] OFS_MASK      = 8'h08;
  localparam logic [7:0] OFS_CONTROL   = 8'h0c;
  localparam logic [7:0] OFS_RX_COUNT  = 8'h10;
  localparam logic [7:0] OFS_RX_NEXT   = 8'h14;
  localparam logic [7:0] OFS_TX_COUNT  = 8'h18;
  localparam logic [7:0] OFS_TX_NEXT   = 8'h1c;

  // ****************************************************************
  // Bit positions shared by status, event and mask registers, and the control register bit
  // ****************************************************************
  localparam int unsigned BIT_ARB_LOST = 0;
  localparam int unsigned BIT_TX_COMP  = 1;
  localparam int unsigned BIT_CLK_WAIT = 2;
  localparam int unsigned BIT_END_SLV  = 3;
  localparam int unsigned BIT_END_RX   = 4;
  localparam int unsigned BIT_END_TX   = 5;
  localparam int unsigned BIT_RX_FULL  = 6;

  localparam int unsigned BIT_HALF_DUPLEX = 0;

  // ****************************************************************
  // Reset values and the counter step of one
  // ****************************************************************
  localparam logic [CNT_W-1:0]  CNT_RESET  = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE    = 16'h0001;
  localparam logic [EVT_W-1:0]  EVT_RESET  = 7'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000;

endpackage

/* hdl/pin_sync_edge.sv */
// Two-stage synchroniser for a bus pin with edge detection
module pin_sync_edge (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // First stage feeds only the second; edges come from later stages
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;
  assign fall  = ~sync_reg & prev_reg;

endmodule

/* hdl/read_clear_flag.sv */
// Sticky flag set by hardware and cleared by a read
module read_clear_flag (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);

  logic flag_reg;

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge mclk) begin
    if (srst) begin
      flag_reg <= 1'b0;
    end else if (set) begin
      flag_reg <= 1'b1;
    end else if (clr) begin
      flag_reg <= 1'b0;
    end
  end

  assign flag = flag_reg;

endmodule

/* hdl/two_wire_status_flags.sv */
// Status flags, DMA counters and interrupt of a two-wire controller
//
// Functional notes
// - Arbitration-lost flag sets in master mode when another master wins; read clears.
// - Transmission-complete sets in the same cycle as arbitration-lost.
// - Clock-wait flag high while slave stretches clock for unready holding buffer.
// - End-of-slave-access sets when slave access ends; read clears.
// - End-of-receive flag sets when receive counter reaches zero; counter writes clear.
// - End-of-transmit flag sets when transmit counter reaches zero; counter writes clear.
// - Receive-full high only while both receive counters are zero.
// - Transmit next counter is a 16-bit read/write field, upper bits read zero.
// - In half-duplex the receive next counter takes the transmit next value.
//
// Added by the designer: the register addresses and strobed register access.
module two_wire_status_flags (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  output logic             irq,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  input  wire logic        master_mode,
  input  wire logic        sda_drive_low,
  input  wire logic        xfer_start,
  input  wire logic        xfer_done,
  input  wire logic        slave_access_active,
  input  wire logic        slave_transmit,
  input  wire logic        byte_end,
  input  wire logic        thr_loaded,
  input  wire logic        rhr_loaded,
  input  wire logic        rx_dma_xfer,
  input  wire logic        tx_dma_xfer,
  output logic             clock_wait_state_flag
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [15:0] receive_counter_reg;
  logic [15:0] receive_next_counter_reg;
  logic [15:0] transmit_counter_reg;
  logic [15:0] transmit_next_counter_reg;
  logic [6:0]  event_reg;
  logic [6:0]  mask_reg;
  logic        half_duplex_reg;
  logic        transmission_complete_flag;
  logic        end_of_receive_buffer_flag;
  logic        end_of_transmit_buffer_flag;
  logic        stretch_reg;
  logic        slave_active_prev_reg;
  logic        rx_full_prev_reg;
  logic [31:0] rdata_reg;
  logic        irq_reg;
  logic        scl_out_reg;
  logic        arbitration_lost_flag;
  logic        end_of_slave_access_flag;
  logic        scl_level;
  logic        scl_rise;
  logic        sda_level;
  logic        status_rd;
  logic        wr_rx_count;
  logic        wr_rx_next;
  logic        wr_tx_count;
  logic        wr_tx_next;
  logic        arb_evt;
  logic        eos_evt;
  logic        end_of_receive_buffer_flag_evt;
  logic        end_of_transmit_buffer_flag_evt;
  logic        receive_buffers_full_flag;
  logic [6:0]  status_bits;
  logic [6:0]  event_set;

  // Register hit test shared by every strobe decode
  function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] ofs);
    hit = strobe && (a == ofs);
  endfunction

  // Counter reaching zero on this transfer
  function automatic logic last_xfer(input logic xfer, input logic [15:0] cnt);
    last_xfer = xfer && (cnt == twi_flags_pkg::CNT_ONE);
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  pin_sync_edge scl_sync (
    .mclk   (mclk),
    .srst   (srst),
    .pin_in (scl_in),
    .level  (scl_level),
    .rise   (scl_rise),
    .fall   ()
  );

  pin_sync_edge sda_sync (
    .mclk   (mclk),
    .srst   (srst),
    .pin_in (sda_in),
    .level  (sda_level),
    .rise   (),
    .fall   ()
  );

  // ****************************************************************
  // Strobe decode and flag events
  // ****************************************************************
  assign status_rd   = hit(rd, addr, twi_flags_pkg::OFS_STATUS);
  assign wr_rx_count = hit(wr, addr, twi_flags_pkg::OFS_RX_COUNT);
  assign wr_rx_next  = hit(wr, addr, twi_flags_pkg::OFS_RX_NEXT);
  assign wr_tx_count = hit(wr, addr, twi_flags_pkg::OFS_TX_COUNT);
  assign wr_tx_next  = hit(wr, addr, twi_flags_pkg::OFS_TX_NEXT);

  // Released SDA seen low on a rising SCL means another master won
  assign arb_evt   = master_mode && scl_rise && !sda_drive_low && !sda_level;
  assign eos_evt   = !master_mode && slave_active_prev_reg && !slave_access_active;
  assign end_of_receive_buffer_flag_evt = last_xfer(rx_dma_xfer, receive_counter_reg);
  assign end_of_transmit_buffer_flag_evt = last_xfer(tx_dma_xfer, transmit_counter_reg);
  // Level from the live counters, so any nonzero write drops it at once
  assign receive_buffers_full_flag = (receive_counter_reg == twi_flags_pkg::CNT_RESET) &&
                                     (receive_next_counter_reg == twi_flags_pkg::CNT_RESET);

  // Read-cleared flags; set wins over the clearing read
  read_clear_flag arb_flag (
    .mclk (mclk),
    .srst (srst),
    .set  (arb_evt),
    .clr  (status_rd),
    .flag (arbitration_lost_flag)
  );

  read_clear_flag eos_flag (
    .mclk (mclk),
    .srst (srst),
    .set  (eos_evt),
    .clr  (status_rd),
    .flag (end_of_slave_access_flag)
  );

  // Slave access history for the falling-edge detect
  always_ff @(posedge mclk) begin
    if (srst) begin
      slave_active_prev_reg <= 1'b0;
    end else begin
      slave_active_prev_reg <= slave_access_active;
    end
  end

  // Completion is forced by arbitration loss; a new transfer clears it
  always_ff @(posedge mclk) begin
    if (srst) begin
      transmission_complete_flag <= 1'b1;
    end else if (arb_evt || xfer_done) begin
      transmission_complete_flag <= 1'b1;
    end else if (xfer_start) begin
      transmission_complete_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // Slave clock stretching
  // ****************************************************************
  // Hold SCL low after a character until the holding buffer is ready
  always_ff @(posedge mclk) begin
    if (srst) begin
      stretch_reg <= 1'b0;
    end else if (master_mode || !slave_access_active) begin
      stretch_reg <= 1'b0;
    end else if (stretch_reg) begin
      stretch_reg <= slave_transmit ? !thr_loaded : rhr_loaded;
    end else if (byte_end && !scl_level) begin
      stretch_reg <= slave_transmit ? !thr_loaded : rhr_loaded;
    end
  end

  // Open-drain clock: only ever pulls low
  always_ff @(posedge mclk) begin
    if (srst) begin
      scl_out_reg <= 1'b0;
    end else begin
      scl_out_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Receive DMA counters
  // ****************************************************************
  // Software writes beat hardware; an empty counter reloads from next
  always_ff @(posedge mclk) begin
    if (srst) begin
      receive_counter_reg <= twi_flags_pkg::CNT_RESET;
    end else if (wr_rx_count) begin
      receive_counter_reg <= wdata[15:0];
    end else if (end_of_receive_buffer_flag_evt || receive_counter_reg == twi_flags_pkg::CNT_RESET) begin
      receive_counter_reg <= receive_next_counter_reg;
    end else if (rx_dma_xfer) begin
      receive_counter_reg <= receive_counter_reg - twi_flags_pkg::CNT_ONE;
    end
  end

  // Half-duplex: a transmit next write lands here too
  always_ff @(posedge mclk) begin
    if (srst) begin
      receive_next_counter_reg <= twi_flags_pkg::CNT_RESET;
    end else if (wr_rx_next || (half_duplex_reg && wr_tx_next)) begin
      receive_next_counter_reg <= wdata[15:0];
    end else if (end_of_receive_buffer_flag_evt || receive_counter_reg == twi_flags_pkg::CNT_RESET) begin
      receive_next_counter_reg <= twi_flags_pkg::CNT_RESET;
    end
  end

  // ****************************************************************
  // Transmit DMA counters
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      transmit_counter_reg <= twi_flags_pkg::CNT_RESET;
    end else if (wr_tx_count) begin
      transmit_counter_reg <= wdata[15:0];
    end else if (end_of_transmit_buffer_flag_evt || transmit_counter_reg == twi_flags_pkg::CNT_RESET) begin
      transmit_counter_reg <= transmit_next_counter_reg;
    end else if (tx_dma_xfer) begin
      transmit_counter_reg <= transmit_counter_reg - twi_flags_pkg::CNT_ONE;
    end
  end

  // Only the low half of the bus word is kept
  always_ff @(posedge mclk) begin
    if (srst) begin
      transmit_next_counter_reg <= twi_flags_pkg::CNT_RESET;
    end else if (wr_tx_next || (half_duplex_reg && wr_rx_next)) begin
      transmit_next_counter_reg <= wdata[15:0];
    end else if (end_of_transmit_buffer_flag_evt || transmit_counter_reg == twi_flags_pkg::CNT_RESET) begin
      transmit_next_counter_reg <= twi_flags_pkg::CNT_RESET;
    end
  end

  // ****************************************************************
  // End-of-buffer flags
  // ****************************************************************
  // Reaching zero wins over a coinciding counter write
  always_ff @(posedge mclk) begin
    if (srst) begin
      end_of_receive_buffer_flag <= 1'b0;
    end else if (end_of_receive_buffer_flag_evt) begin
      end_of_receive_buffer_flag <= 1'b1;
    end else if (wr_rx_count || wr_rx_next) begin
      end_of_receive_buffer_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      end_of_transmit_buffer_flag <= 1'b0;
    end else if (end_of_transmit_buffer_flag_evt) begin
      end_of_transmit_buffer_flag <= 1'b1;
    end else if (wr_tx_count || wr_tx_next) begin
      end_of_transmit_buffer_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // Interrupt events, mask and control
  // ****************************************************************
  always_comb begin
    status_bits = twi_flags_pkg::EVT_RESET;
    status_bits[twi_flags_pkg::BIT_ARB_LOST] = arbitration_lost_flag;
    status_bits[twi_flags_pkg::BIT_TX_COMP]  = transmission_complete_flag;
    status_bits[twi_flags_pkg::BIT_CLK_WAIT] = stretch_reg;
    status_bits[twi_flags_pkg::BIT_END_SLV]  = end_of_slave_access_flag;
    status_bits[twi_flags_pkg::BIT_END_RX]   = end_of_receive_buffer_flag;
    status_bits[twi_flags_pkg::BIT_END_TX]   = end_of_transmit_buffer_flag;
    status_bits[twi_flags_pkg::BIT_RX_FULL]  = receive_buffers_full_flag;
  end

  // Each event pulses once; level flags give their rising edge
  always_comb begin
    event_set = twi_flags_pkg::EVT_RESET;
    event_set[twi_flags_pkg::BIT_ARB_LOST] = arb_evt;
    event_set[twi_flags_pkg::BIT_TX_COMP]  = (arb_evt || xfer_done) && !transmission_complete_flag;
    event_set[twi_flags_pkg::BIT_CLK_WAIT] = !stretch_reg && !master_mode && slave_access_active &&
                                             byte_end && !scl_level &&
                                             (slave_transmit ? !thr_loaded : rhr_loaded);
    event_set[twi_flags_pkg::BIT_END_SLV]  = eos_evt;
    event_set[twi_flags_pkg::BIT_END_RX]   = end_of_receive_buffer_flag_evt;
    event_set[twi_flags_pkg::BIT_END_TX]   = end_of_transmit_buffer_flag_evt;
    event_set[twi_flags_pkg::BIT_RX_FULL]  = receive_buffers_full_flag && !rx_full_prev_reg;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_full_prev_reg <= 1'b1;
    end else begin
      rx_full_prev_reg <= receive_buffers_full_flag;
    end
  end

  // Write one to clear; a new event in the same cycle stays
  always_ff @(posedge mclk) begin
    if (srst) begin
      event_reg <= twi_flags_pkg::EVT_RESET;
    end else if (hit(wr, addr, twi_flags_pkg::OFS_EVENT)) begin
      event_reg <= (event_reg & ~wdata[6:0]) | event_set;
    end else begin
      event_reg <= event_reg | event_set;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      mask_reg <= twi_flags_pkg::EVT_RESET;
    end else if (hit(wr, addr, twi_flags_pkg::OFS_MASK)) begin
      mask_reg <= wdata[6:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      half_duplex_reg <= 1'b0;
    end else if (hit(wr, addr, twi_flags_pkg::OFS_CONTROL)) begin
      half_duplex_reg <= wdata[twi_flags_pkg::BIT_HALF_DUPLEX];
    end
  end

  // Registered so the output never glitches on a flag update
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(event_reg & mask_reg);
    end
  end

  // ****************************************************************
  // Read data, one cycle after the strobe
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_reg <= twi_flags_pkg::DATA_ZERO;
    end else if (rd) begin
      case (addr)
        twi_flags_pkg::OFS_STATUS:   rdata_reg <= {25'h0000000, status_bits};
        twi_flags_pkg::OFS_EVENT:    rdata_reg <= {25'h0000000, event_reg};
        twi_flags_pkg::OFS_MASK:     rdata_reg <= {25'h0000000, mask_reg};
        twi_flags_pkg::OFS_CONTROL:  rdata_reg <= {31'h00000000, half_duplex_reg};
        twi_flags_pkg::OFS_RX_COUNT: rdata_reg <= {16'h0000, receive_counter_reg};
        twi_flags_pkg::OFS_RX_NEXT:  rdata_reg <= {16'h0000, receive_next_counter_reg};
        twi_flags_pkg::OFS_TX_COUNT: rdata_reg <= {16'h0000, transmit_counter_reg};
        twi_flags_pkg::OFS_TX_NEXT:  rdata_reg <= {16'h0000, transmit_next_counter_reg};
        default:                     rdata_reg <= twi_flags_pkg::DATA_ZERO;
      endcase
    end else begin
      rdata_reg <= twi_flags_pkg::DATA_ZERO;
    end
  end

  assign rdata                 = rdata_reg;
  assign irq                   = irq_reg;
  assign scl_out               = scl_out_reg;
  assign scl_oe                = stretch_reg;
  assign clock_wait_state_flag = stretch_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  arb_master_only_a: assert property (@(posedge mclk) disable iff (srst)
    arb_evt |=> arbitration_lost_flag && $past(master_mode))
    else $error("arbitration loss flagged outside master mode");

  arb_sets_comp_a: assert property (@(posedge mclk) disable iff (srst)
    arb_evt |=> transmission_complete_flag && arbitration_lost_flag)
    else $error("arbitration loss without completion");

  stretch_cause_a: assert property (@(posedge mclk) disable iff (srst)
    $rose(stretch_reg) |-> $past(byte_end && slave_access_active && !master_mode))
    else $error("clock stretched without a character boundary");

  slave_end_a: assert property (@(posedge mclk) disable iff (srst)
    (!master_mode && $fell(slave_access_active)) |=> end_of_slave_access_flag)
    else $error("end of slave access not flagged");

  rx_end_a: assert property (@(posedge mclk) disable iff (srst)
    (rx_dma_xfer && receive_counter_reg == 16'h0001) |=> end_of_receive_buffer_flag)
    else $error("receive end flag missing");

  tx_end_clear_a: assert property (@(posedge mclk) disable iff (srst)
    ((wr_tx_count || wr_tx_next) && !end_of_transmit_buffer_flag_evt) |=> !end_of_transmit_buffer_flag)
    else $error("transmit end flag not cleared by counter write");

  rx_full_read_a: assert property (@(posedge mclk) disable iff (srst)
    status_rd |=> rdata[6] == $past(receive_counter_reg == 16'h0000 && receive_next_counter_reg == 16'h0000))
    else $error("receive full flag wrong");

  tx_next_rw_a: assert property (@(posedge mclk) disable iff (srst)
    (wr_tx_next && !tx_dma_xfer && transmit_counter_reg > 16'h0001) ##1 !wr ##1 (rd && addr == 8'h1c)
    |=> rdata == {16'h0000, $past(wdata[15:0], 3)})
    else $error("transmit next counter readback wrong");

  half_duplex_a: assert property (@(posedge mclk) disable iff (srst)
    (half_duplex_reg && wr_tx_next) |=> receive_next_counter_reg == transmit_next_counter_reg)
    else $error("half-duplex next counters differ");

  set_wins_a: assert property (@(posedge mclk) disable iff (srst)
    (eos_evt && status_rd) |=> end_of_slave_access_flag)
    else $error("flag event lost to clearing read");

endmodule

/* tb/two_wire_far_end.sv */
// Far-end two-wire bus party: rival master plus pull-ups
module two_wire_far_end (
  input  wire logic scl_oe,
  output logic      scl_pin,
  output logic      sda_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_pull;
  logic sda_pull;
  // Open-drain wires with pull-ups, so whoever pulls low wins
  assign scl_pin = !(scl_pull || scl_oe);
  assign sda_pin = !sda_pull;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // Rival holds SDA low over one 320 ns bit; SCL stays high outside it
  task automatic clash();
    sda_pull = 1'b1;
    scl_pull = 1'b1;
    #160;
    scl_pull = 1'b0;
    #160;
    sda_pull = 1'b0;
  endtask
endmodule

/* tb/two_wire_status_flags_bench.sv */
// Self-checking bench for the two-wire status flag block
module two_wire_status_flags_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0, rd = 1'b0, master_mode = 1'b0, sda_drive_low = 1'b0;
  logic        xfer_start = 1'b0, xfer_done = 1'b0, slave_access_active = 1'b0;
  logic        slave_transmit = 1'b0, byte_end = 1'b0, thr_loaded = 1'b0, rhr_loaded = 1'b0;
  logic        rx_dma_xfer = 1'b0, tx_dma_xfer = 1'b0;
  logic [31:0] rdata, v;
  logic        irq, scl_in, scl_out, scl_oe, sda_in, clock_wait_state_flag;
  int          miscompares = 0;
  int          checks = 0;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  // Writes carry data, reads carry the expected word
  // An empty transmit counter pulls the next value in, so the first word reads back from 18
  row_t rows[12] = '{'{1'b0, 8'h00, 32'h0, 32'h42}, '{1'b1, 8'h1c, 32'hffff_abcd, 32'h0},
    '{1'b0, 8'h18, 32'h0, 32'h0000_abcd}, '{1'b1, 8'h10, 32'h2, 32'h0}, '{1'b0, 8'h00, 32'h0, 32'h02},
    '{1'b1, 8'h0c, 32'h1, 32'h0}, '{1'b1, 8'h1c, 32'h5, 32'h0}, '{1'b0, 8'h1c, 32'h0, 32'h5},
    '{1'b0, 8'h14, 32'h0, 32'h5},
    '{1'b1, 8'h0c, 32'h0, 32'h0}, '{1'b1, 8'h40, 32'h1234, 32'h0}, '{1'b0, 8'h40, 32'h0, 32'h0}};

  always #20 mclk = ~mclk;

  two_wire_status_flags dut_u (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
    .master_mode(master_mode), .sda_drive_low(sda_drive_low), .xfer_start(xfer_start),
    .xfer_done(xfer_done), .slave_access_active(slave_access_active), .slave_transmit(slave_transmit),
    .byte_end(byte_end), .thr_loaded(thr_loaded), .rhr_loaded(rhr_loaded), .rx_dma_xfer(rx_dma_xfer),
    .tx_dma_xfer(tx_dma_xfer), .clock_wait_state_flag(clock_wait_state_flag));

  two_wire_far_end far_u (.scl_oe(scl_oe), .scl_pin(scl_in), .sda_pin(sda_in));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_cy(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Counter at one with an empty next slot: one transfer ends the buffer
  task automatic dma_end(input logic [7:0] ofs, input int b, input logic tx);
    wr_reg(ofs + 8'h04, 32'h0);
    wr_reg(ofs, 32'h1);
    @(posedge mclk);
    rx_dma_xfer <= !tx;
    tx_dma_xfer <= tx;
    @(posedge mclk);
    rx_dma_xfer <= 1'b0;
    tx_dma_xfer <= 1'b0;
    wait_cy(2);
    rd_reg(8'h00);
    chk("end flag set", 32'(v[b]), 32'h1);
    wr_reg(ofs + 8'h04, 32'h3);
    rd_reg(8'h00);
    chk("end flag clear", 32'(v[b]), 32'h0);
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog at 5000 cycles, far past the roughly 120 cycles the tests need
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    wait_cy(10);
    srst <= 1'b0;
    chk("reset outputs", {rdata[29:0], irq, scl_oe}, 32'h0);
    foreach (rows[i]) begin
      if (rows[i].w)
        wr_reg(rows[i].a, rows[i].d);
      else begin
        rd_reg(rows[i].a);
        chk("register row", v, rows[i].e);
      end
    end
    dma_end(8'h10, 4, 1'b0);
    dma_end(8'h18, 5, 1'b1);
    // Arbitration loss: start a transfer so completion is low first
    master_mode <= 1'b1;
    xfer_start <= 1'b1;
    wait_cy(1);
    xfer_start <= 1'b0;
    rd_reg(8'h00);
    far_u.clash();
    wait_cy(6);
    rd_reg(8'h00);
    chk("arb and complete", {30'h0, v[1:0]}, 32'h3);
    rd_reg(8'h00);
    chk("arb read clear", 32'(v[0]), 32'h0);
    // Interrupt raised, masked, cleared
    wr_reg(8'h08, 32'h7f);
    wait_cy(2);
    chk("irq on", 32'(irq), 32'h1);
    wr_reg(8'h08, 32'h0);
    wait_cy(2);
    chk("irq masked", 32'(irq), 32'h0);
    wr_reg(8'h08, 32'h7f);
    wr_reg(8'h04, 32'h7f);
    wait_cy(2);
    chk("irq cleared", 32'(irq), 32'h0);
    // Slave stretch while the transmit holding buffer is empty
    master_mode <= 1'b0;
    slave_access_active <= 1'b1;
    slave_transmit <= 1'b1;
    far_u.scl_pull = 1'b1;
    wait_cy(4);
    byte_end <= 1'b1;
    wait_cy(1);
    byte_end <= 1'b0;
    wait_cy(2);
    chk("stretch on", {30'h0, scl_oe, clock_wait_state_flag}, 32'h3);
    thr_loaded <= 1'b1;
    wait_cy(2);
    chk("stretch off", {30'h0, scl_oe, clock_wait_state_flag}, 32'h0);
    far_u.scl_pull = 1'b0;
    slave_access_active <= 1'b0;
    wait_cy(3);
    rd_reg(8'h00);
    chk("end of access", 32'(v[3]), 32'h1);
    rd_reg(8'h00);
    chk("end of access clear", 32'(v[3]), 32'h0);
    // Reset again in mid-run: status returns to its reset image
    srst <= 1'b1;
    wait_cy(3);
    srst <= 1'b0;
    rd_reg(8'h00);
    chk("status after reset", v, 32'h42);
    end_of_test();
  end
endmodule
